// ### logic/instruction_timing_decode.sv
// Purpose: Decode addressing modes and report execution time per instruction.
// Assumes: Fetch pulses valid with both bytes and all side inputs.
// Notes: Time is held until the sequencer accepts it.
//
// How it works
// - Paired indirect and indexed forms share an opcode, split by another bit.
// - Second byte bit zero clear: normal/short; set: autoinc/long; rest is register.
// - Short jump/call offset is low three opcode bits over next byte, signed.
// - Every duration is counted in state times.
// - Flag branches take 4 not taken, 8 taken.
// - Byte decrement branch and bit branches take 5 or 9.
// - Word decrement branch takes 6 or 10.
// - Normalize takes 8 plus one per shift, 9 for none.
// - Word and byte shifts take 6 plus one per bit, 7 for none.
// - Doubleword shifts take 7 plus one per bit, 8 for none.
// - Block move takes 6 plus 8, 11 or 14 per word.
// - Interruptible block move takes 7 plus per-word plus 14 per interrupt.
// - Idle/powerdown entry takes 12 with valid key, 28 otherwise.
// - Table jump takes 15, 18 or 21 by operand placement.
// - Calls take 15/11 register stack, 18/13 memory stack.
// - Return takes 16/11 register stack, 22/14 memory stack.
// - Trap takes 19/16 register stack, 25/18 memory stack.
// - Signed word divide takes 26 direct, 27 immediate, more otherwise.
// - Word add takes 4 direct, 5 immediate, 6/8 indirect, 7/9 autoinc.
`timescale 1ns/10ps
module instruction_timing_decode
    import instr_timing_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] second_byte_i,
    input wire logic branch_taken_i,
    input wire logic key_valid_i,
    input wire logic mode_1mbyte_i,
    input wire logic stack_in_memory_i,
    input wire logic operand_in_memory_i,
    input wire logic [1:0] move_place_i,
    input wire logic [COUNT_W-1:0] shift_count_i,
    input wire logic [COUNT_W-1:0] word_count_i,
    input wire logic [COUNT_W-1:0] irq_count_i,
    input wire logic exec_start_i,
    output logic time_valid_o,
    output logic [TIME_W-1:0] state_time_o,
    output logic [2:0] addr_mode_o,
    output logic [6:0] word_reg_o,
    output logic [10:0] short_disp_o,
    output logic busy_o
);

    typedef struct packed {
        seq_state_e state;
        logic [TIME_W-1:0] time_val;
        logic [2:0] mode;
        logic [6:0] wreg;
        logic [10:0] disp;
    } core_s;

    core_s cur;
    core_s next_cur;

    addr_mode_e dec_mode;
    logic [6:0] dec_wreg;
    logic [10:0] dec_disp;
    logic [TIME_W-1:0] var_base;
    logic [TIME_W-1:0] var_zero;
    logic [TIME_W-1:0] var_per_word;
    logic var_is_move;
    logic var_used;
    logic [COUNT_W-1:0] var_irq;
    logic [TIME_W-1:0] var_time;
    logic [TIME_W-1:0] fixed_time;
    logic [TIME_W-1:0] new_time;

    ////////////////////////////////////////////////////////////////////////////
    addr_mode_resolve u_mode
    (
        .opcode_i(opcode_i),
        .second_byte_i(second_byte_i),
        .mode_o(dec_mode),
        .word_reg_o(dec_wreg),
        .short_disp_o(dec_disp)
    );

    variable_time_calc u_var
    (
        .base_i(var_base),
        .zero_i(var_zero),
        .shift_count_i(shift_count_i),
        .per_word_i(var_per_word),
        .word_count_i(word_count_i),
        .irq_count_i(var_irq),
        .is_move_i(var_is_move),
        .time_o(var_time)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data-dependent families feed the shared calculator
    always_comb
    begin
        var_base = T_SHIFT_BASE;
        var_zero = T_SHIFT_ZERO;
        var_per_word = T_WORD_RR;
        var_is_move = 1'b0;
        var_used = 1'b0;
        var_irq = '0;
        case (move_place_i)
            PLACE_RR: var_per_word = T_WORD_RR;
            PLACE_MR: var_per_word = T_WORD_MR;
            default: var_per_word = T_WORD_MM;
        endcase
        if (opcode_i == OP_NORMALIZE)
        begin
            var_base = T_NORM_BASE;
            var_zero = T_NORM_ZERO;
            var_used = 1'b1;
        end
        else if (opcode_i == OP_SHIFT_LONG_LEFT || opcode_i == OP_SHIFT_LONG_RIGHT ||
                 opcode_i == OP_SHIFT_LONG_ARITH)
        begin
            var_base = T_DSHIFT_BASE;
            var_zero = T_DSHIFT_ZERO;
            var_used = 1'b1;
        end
        else if ((opcode_i[7:4] == GRP_WORD_SHIFT || opcode_i[7:4] == GRP_BYTE_SHIFT) &&
                 (opcode_i[3:0] == 4'h8 || opcode_i[3:0] == 4'h9 || opcode_i[3:0] == 4'hA))
        begin
            var_base = T_SHIFT_BASE;
            var_zero = T_SHIFT_ZERO;
            var_used = 1'b1;
        end
        else if (opcode_i == OP_BLOCK_MOVE)
        begin
            var_base = T_BLOCK_MOVE_BASE;
            var_is_move = 1'b1;
            var_used = 1'b1;
        end
        else if (opcode_i == OP_INTERRUPTIBLE_BLOCK_MOVE)
        begin
            var_base = T_INTERRUPTIBLE_BLOCK_MOVE_BASE;
            var_is_move = 1'b1;
            var_irq = irq_count_i;
            var_used = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fixed-table families; all figures are state times
    always_comb
    begin
        fixed_time = T_DEFAULT;
        if (opcode_i[7:4] == GRP_COND_BRANCH)
            fixed_time = branch_taken_i ? T_COND_TAKEN : T_COND_NOT;
        else if (opcode_i == OP_BYTE_DECREMENT_BRANCH || opcode_i[7:3] == GRP_BIT_BRANCH ||
                 opcode_i[7:3] == 5'h07)
            fixed_time = branch_taken_i ? T_BIT_TAKEN : T_BIT_NOT;
        else if (opcode_i == OP_WORD_DECREMENT_BRANCH)
            fixed_time = branch_taken_i ? T_WORD_DEC_TAKEN : T_WORD_DEC_NOT;
        else if (opcode_i[7:3] == GRP_SHORT_JUMP)
            fixed_time = T_SHORT_JUMP;
        else if (opcode_i == OP_IDLE_POWERDOWN_ENTRY)
            fixed_time = key_valid_i ? T_IDLE_VALID : T_IDLE_INVALID;
        else if (opcode_i == OP_TABLE_INDEXED_JUMP)
        begin
            case (move_place_i)
                PLACE_RR: fixed_time = T_TABLE_INDEXED_JUMP_RR;
                PLACE_MR: fixed_time = T_TABLE_INDEXED_JUMP_MR;
                default: fixed_time = T_TABLE_INDEXED_JUMP_MM;
            endcase
        end
        else if (opcode_i == OP_LONG_CALL || opcode_i[7:3] == GRP_SHORT_CALL)
        begin
            if (stack_in_memory_i)
                fixed_time = mode_1mbyte_i ? T_CALL_MEM_1M : T_CALL_MEM_64K;
            else
                fixed_time = mode_1mbyte_i ? T_CALL_REG_1M : T_CALL_REG_64K;
        end
        else if (opcode_i == OP_SUBROUTINE_RETURN)
        begin
            if (stack_in_memory_i)
                fixed_time = mode_1mbyte_i ? T_RET_MEM_1M : T_RET_MEM_64K;
            else
                fixed_time = mode_1mbyte_i ? T_RET_REG_1M : T_RET_REG_64K;
        end
        else if (opcode_i == OP_TRAP)
        begin
            if (stack_in_memory_i)
                fixed_time = mode_1mbyte_i ? T_TRAP_MEM_1M : T_TRAP_MEM_64K;
            else
                fixed_time = mode_1mbyte_i ? T_TRAP_REG_1M : T_TRAP_REG_64K;
        end
        else if (opcode_i[7:2] == OP_DIV_DIRECT[7:2])
        begin
            case (dec_mode)
                MODE_DIRECT: fixed_time = T_DIV_DIRECT;
                MODE_IMMED: fixed_time = T_DIV_IMMED;
                MODE_IND_NORMAL: fixed_time = operand_in_memory_i ? T_DIV_IND_M : T_DIV_IND_R;
                MODE_IND_AUTOINC:
                    fixed_time = operand_in_memory_i ? T_DIV_AUTO_M : T_DIV_AUTO_R;
                MODE_IDX_SHORT:
                    fixed_time = operand_in_memory_i ? T_DIV_SHORT_M : T_DIV_SHORT_R;
                default: fixed_time = operand_in_memory_i ? T_DIV_LONG_M : T_DIV_LONG_R;
            endcase
        end
        else if (opcode_i[7:2] == OP_ADD_DIRECT[7:2])
        begin
            case (dec_mode)
                MODE_DIRECT: fixed_time = T_ADD_DIRECT;
                MODE_IMMED: fixed_time = T_ADD_IMMED;
                MODE_IND_NORMAL: fixed_time = operand_in_memory_i ? T_ADD_IND_M : T_ADD_IND_R;
                MODE_IND_AUTOINC:
                    fixed_time = operand_in_memory_i ? T_ADD_AUTO_M : T_ADD_AUTO_R;
                MODE_IDX_SHORT:
                    fixed_time = operand_in_memory_i ? T_ADD_SHORT_M : T_ADD_SHORT_R;
                default: fixed_time = operand_in_memory_i ? T_ADD_LONG_M : T_ADD_LONG_R;
            endcase
        end
    end

    assign new_time = var_used ? var_time : fixed_time;

    ////////////////////////////////////////////////////////////////////////////
    // Handshake with the sequencer
    always_comb
    begin
        next_cur = cur;
        case (cur.state)
            ST_IDLE:
            begin
                if (instr_valid_i)
                begin
                    next_cur.state = ST_READY;
                    next_cur.time_val = new_time;
                    next_cur.mode = dec_mode;
                    next_cur.wreg = dec_wreg;
                    next_cur.disp = dec_disp;
                end
            end
            ST_READY:
            begin
                if (exec_start_i)
                    next_cur.state = ST_EXEC;
            end
            ST_EXEC:
            begin
                // One cycle in execution before the next decode is taken
                next_cur.state = ST_IDLE;
            end
            default:
            begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cur <= '{state: ST_IDLE, time_val: '0, mode: 3'h0, wreg: 7'h00, disp: 11'h000};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign time_valid_o = (cur.state == ST_READY);
    assign busy_o = (cur.state != ST_IDLE);
    assign state_time_o = cur.time_val;
    assign addr_mode_o = cur.mode;
    assign word_reg_o = cur.wreg;
    assign short_disp_o = cur.disp;

endmodule : instruction_timing_decode

// ### logic/instr_timing_pkg.sv
// Purpose: Shared constants for the instruction decode and timing block.
// Assumes: Opcodes as seen by the fetch unit, one byte each.
// Notes: Times are in state times.
package instr_timing_pkg;

    // Opcodes
    localparam logic [7:0] OP_BYTE_DECREMENT_BRANCH = 8'hE0;
    localparam logic [7:0] OP_WORD_DECREMENT_BRANCH = 8'hE1;
    localparam logic [7:0] OP_TABLE_INDEXED_JUMP = 8'hE2;
    localparam logic [7:0] OP_LONG_CALL = 8'hEF;
    localparam logic [7:0] OP_SUBROUTINE_RETURN = 8'hF0;
    localparam logic [7:0] OP_TRAP = 8'hF7;
    localparam logic [7:0] OP_IDLE_POWERDOWN_ENTRY = 8'hF6;
    localparam logic [7:0] OP_BLOCK_MOVE = 8'hC1;
    localparam logic [7:0] OP_INTERRUPTIBLE_BLOCK_MOVE = 8'hCD;
    localparam logic [7:0] OP_NORMALIZE = 8'h0F;
    localparam logic [7:0] OP_SHIFT_LONG_LEFT = 8'h0D;
    localparam logic [7:0] OP_SHIFT_LONG_RIGHT = 8'h0C;
    localparam logic [7:0] OP_SHIFT_LONG_ARITH = 8'h0E;
    localparam logic [7:0] OP_DIV_DIRECT = 8'h8C;
    localparam logic [7:0] OP_DIV_IMMED = 8'h8D;
    localparam logic [7:0] OP_DIV_INDIRECT = 8'h8E;
    localparam logic [7:0] OP_DIV_INDEXED = 8'h8F;
    localparam logic [7:0] OP_ADD_DIRECT = 8'h64;
    localparam logic [7:0] OP_ADD_IMMED = 8'h65;
    localparam logic [7:0] OP_ADD_INDIRECT = 8'h66;
    localparam logic [7:0] OP_ADD_INDEXED = 8'h67;
    // Opcode groups by upper bits
    localparam logic [4:0] GRP_SHORT_JUMP = 5'h04;
    localparam logic [4:0] GRP_SHORT_CALL = 5'h05;
    localparam logic [4:0] GRP_BIT_BRANCH = 5'h06;
    localparam logic [3:0] GRP_COND_BRANCH = 4'hD;
    localparam logic [3:0] GRP_WORD_SHIFT = 4'h0;
    localparam logic [3:0] GRP_BYTE_SHIFT = 4'h1;

    localparam int TIME_W = 12;
    localparam int COUNT_W = 8;

    // Branch times
    localparam logic [TIME_W-1:0] T_COND_NOT = 12'h004;
    localparam logic [TIME_W-1:0] T_COND_TAKEN = 12'h008;
    localparam logic [TIME_W-1:0] T_BIT_NOT = 12'h005;
    localparam logic [TIME_W-1:0] T_BIT_TAKEN = 12'h009;
    localparam logic [TIME_W-1:0] T_WORD_DEC_NOT = 12'h006;
    localparam logic [TIME_W-1:0] T_WORD_DEC_TAKEN = 12'h00A;
    localparam logic [TIME_W-1:0] T_SHORT_JUMP = 12'h007;
    // Shift family
    localparam logic [TIME_W-1:0] T_NORM_BASE = 12'h008;
    localparam logic [TIME_W-1:0] T_NORM_ZERO = 12'h009;
    localparam logic [TIME_W-1:0] T_SHIFT_BASE = 12'h006;
    localparam logic [TIME_W-1:0] T_SHIFT_ZERO = 12'h007;
    localparam logic [TIME_W-1:0] T_DSHIFT_BASE = 12'h007;
    localparam logic [TIME_W-1:0] T_DSHIFT_ZERO = 12'h008;
    // Block moves
    localparam logic [TIME_W-1:0] T_BLOCK_MOVE_BASE = 12'h006;
    localparam logic [TIME_W-1:0] T_INTERRUPTIBLE_BLOCK_MOVE_BASE = 12'h007;
    localparam logic [TIME_W-1:0] T_WORD_RR = 12'h008;
    localparam logic [TIME_W-1:0] T_WORD_MR = 12'h00B;
    localparam logic [TIME_W-1:0] T_WORD_MM = 12'h00E;
    localparam logic [TIME_W-1:0] T_PER_INTERRUPT = 12'h00E;
    // Special
    localparam logic [TIME_W-1:0] T_IDLE_VALID = 12'h00C;
    localparam logic [TIME_W-1:0] T_IDLE_INVALID = 12'h01C;
    localparam logic [TIME_W-1:0] T_TABLE_INDEXED_JUMP_RR = 12'h00F;
    localparam logic [TIME_W-1:0] T_TABLE_INDEXED_JUMP_MR = 12'h012;
    localparam logic [TIME_W-1:0] T_TABLE_INDEXED_JUMP_MM = 12'h015;
    // Calls, returns, traps: register stack / memory stack, 1-Mbyte / 64-Kbyte
    localparam logic [TIME_W-1:0] T_CALL_REG_1M = 12'h00F;
    localparam logic [TIME_W-1:0] T_CALL_REG_64K = 12'h00B;
    localparam logic [TIME_W-1:0] T_CALL_MEM_1M = 12'h012;
    localparam logic [TIME_W-1:0] T_CALL_MEM_64K = 12'h00D;
    localparam logic [TIME_W-1:0] T_RET_REG_1M = 12'h010;
    localparam logic [TIME_W-1:0] T_RET_REG_64K = 12'h00B;
    localparam logic [TIME_W-1:0] T_RET_MEM_1M = 12'h016;
    localparam logic [TIME_W-1:0] T_RET_MEM_64K = 12'h00E;
    localparam logic [TIME_W-1:0] T_TRAP_REG_1M = 12'h013;
    localparam logic [TIME_W-1:0] T_TRAP_REG_64K = 12'h010;
    localparam logic [TIME_W-1:0] T_TRAP_MEM_1M = 12'h019;
    localparam logic [TIME_W-1:0] T_TRAP_MEM_64K = 12'h012;
    // Division: direct, immediate, ind-normal reg/mem, autoinc reg/mem,
    // short reg/mem, long reg/mem
    localparam logic [TIME_W-1:0] T_DIV_DIRECT = 12'h01A;
    localparam logic [TIME_W-1:0] T_DIV_IMMED = 12'h01B;
    localparam logic [TIME_W-1:0] T_DIV_IND_R = 12'h01C;
    localparam logic [TIME_W-1:0] T_DIV_IND_M = 12'h01F;
    localparam logic [TIME_W-1:0] T_DIV_AUTO_R = 12'h01D;
    localparam logic [TIME_W-1:0] T_DIV_AUTO_M = 12'h020;
    localparam logic [TIME_W-1:0] T_DIV_SHORT_R = 12'h01D;
    localparam logic [TIME_W-1:0] T_DIV_SHORT_M = 12'h020;
    localparam logic [TIME_W-1:0] T_DIV_LONG_R = 12'h01E;
    localparam logic [TIME_W-1:0] T_DIV_LONG_M = 12'h021;
    // Two-operand word add
    localparam logic [TIME_W-1:0] T_ADD_DIRECT = 12'h004;
    localparam logic [TIME_W-1:0] T_ADD_IMMED = 12'h005;
    localparam logic [TIME_W-1:0] T_ADD_IND_R = 12'h006;
    localparam logic [TIME_W-1:0] T_ADD_IND_M = 12'h008;
    localparam logic [TIME_W-1:0] T_ADD_AUTO_R = 12'h007;
    localparam logic [TIME_W-1:0] T_ADD_AUTO_M = 12'h009;
    localparam logic [TIME_W-1:0] T_ADD_SHORT_R = 12'h006;
    localparam logic [TIME_W-1:0] T_ADD_SHORT_M = 12'h008;
    localparam logic [TIME_W-1:0] T_ADD_LONG_R = 12'h007;
    localparam logic [TIME_W-1:0] T_ADD_LONG_M = 12'h009;
    // Fallback for opcodes outside this block's map
    localparam logic [TIME_W-1:0] T_DEFAULT = 12'h004;

    // Placement of block-move and table-jump operands
    localparam logic [1:0] PLACE_RR = 2'h0;
    localparam logic [1:0] PLACE_MR = 2'h1;
    localparam logic [1:0] PLACE_MM = 2'h2;

    typedef enum logic [2:0] {
        MODE_DIRECT = 3'b000,
        MODE_IMMED = 3'b001,
        MODE_IND_NORMAL = 3'b010,
        MODE_IND_AUTOINC = 3'b011,
        MODE_IDX_SHORT = 3'b100,
        MODE_IDX_LONG = 3'b101
    } addr_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READY = 2'b01,
        ST_EXEC = 2'b10
    } seq_state_e;

endpackage : instr_timing_pkg

// ### logic/addr_mode_resolve.sv
// Purpose: Resolve addressing mode and short branch displacement.
// Assumes: Opcode and second instruction byte are valid together.
// Notes: Purely combinational.
`timescale 1ns/10ps
module addr_mode_resolve
    import instr_timing_pkg::*;
(
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] second_byte_i,
    output addr_mode_e mode_o,
    output logic [6:0] word_reg_o,
    output logic [10:0] short_disp_o
);

    always_comb
    begin
        case (opcode_i[1:0])
            2'b00: mode_o = MODE_DIRECT;
            2'b01: mode_o = MODE_IMMED;
            2'b10: mode_o = second_byte_i[0] ? MODE_IND_AUTOINC : MODE_IND_NORMAL;
            default: mode_o = second_byte_i[0] ? MODE_IDX_LONG : MODE_IDX_SHORT;
        endcase
    end

    assign word_reg_o = second_byte_i[7:1];
    assign short_disp_o = {opcode_i[2:0], second_byte_i};

endmodule : addr_mode_resolve

// ### logic/variable_time_calc.sv
// Purpose: Data-dependent parts of execution time.
// Assumes: Counts are known at decode.
// Notes: Move sums truncate to 12 bits for large counts.
`timescale 1ns/10ps
module variable_time_calc
    import instr_timing_pkg::*;
(
    input wire logic [TIME_W-1:0] base_i,
    input wire logic [TIME_W-1:0] zero_i,
    input wire logic [COUNT_W-1:0] shift_count_i,
    input wire logic [TIME_W-1:0] per_word_i,
    input wire logic [COUNT_W-1:0] word_count_i,
    input wire logic [COUNT_W-1:0] irq_count_i,
    input wire logic is_move_i,
    output logic [TIME_W-1:0] time_o
);

    logic [TIME_W-1:0] word_part;
    logic [TIME_W-1:0] irq_part;

    always_comb
    begin
        word_part = TIME_W'(per_word_i * TIME_W'(word_count_i));
        irq_part = TIME_W'(T_PER_INTERRUPT * TIME_W'(irq_count_i));
        if (is_move_i)
            time_o = base_i + word_part + irq_part;
        else if (shift_count_i == '0)
            time_o = zero_i;
        else
            time_o = base_i + TIME_W'(shift_count_i);
    end

endmodule : variable_time_calc

// ### tb/itd_asserts.sv
// Purpose: Port checks for the decode block.
// Assumes: One clock domain.
// Notes: Locals keep take-edge inputs.
`timescale 1ns/10ps
module itd_asserts
    import instr_timing_pkg::*;
(
    input logic clock_i,
    input logic rst_n_i,
    input logic instr_valid_i,
    input logic [7:0] opcode_i,
    input logic [7:0] second_byte_i,
    input logic branch_taken_i,
    input logic key_valid_i,
    input logic exec_start_i,
    input logic time_valid_o,
    input logic [TIME_W-1:0] state_time_o,
    input logic [2:0] addr_mode_o,
    input logic [6:0] word_reg_o,
    input logic [10:0] short_disp_o,
    input logic busy_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    sequence s_take;
        instr_valid_i && !busy_o;
    endsequence
    sequence s_start;
        time_valid_o && exec_start_i;
    endsequence
    property p_answer;
        s_take |=> time_valid_o && busy_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no offer");
    property p_hold;
        time_valid_o && !exec_start_i |=> time_valid_o && $stable(state_time_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("offer not held");
    property p_exec;
        s_start |=> !time_valid_o && busy_o ##1 !busy_o;
    endproperty
    a_exec: assert property (p_exec)
        else $error("no exec cycle");
    property p_reg;
        logic [7:0] b;
        (s_take, b = second_byte_i) |=> word_reg_o == b[7:1];
    endproperty
    a_reg: assert property (p_reg)
        else $error("word reg");
    property p_mode;
        logic [7:0] o, b;
        (s_take, o = opcode_i, b = second_byte_i) |=>
            addr_mode_o == (o[1] ? {o[0], !o[0], b[0]} : {2'b00, o[0]});
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode");
    property p_disp;
        logic [7:0] o, b;
        (s_take, o = opcode_i, b = second_byte_i) |=> short_disp_o == {o[2:0], b};
    endproperty
    a_disp: assert property (p_disp)
        else $error("disp");
    property p_cond;
        logic t;
        (s_take ##0 (opcode_i[7:4] == 4'hD), t = branch_taken_i) |=>
            state_time_o == (t ? 12'h008 : 12'h004);
    endproperty
    a_cond: assert property (p_cond)
        else $error("flag branch");
    property p_bit;
        logic t;
        (s_take ##0 (opcode_i[7:3] == 5'h06), t = branch_taken_i) |=>
            state_time_o == (t ? 12'h009 : 12'h005);
    endproperty
    a_bit: assert property (p_bit)
        else $error("bit branch");
    property p_idle;
        logic k;
        (s_take ##0 (opcode_i == 8'hF6), k = key_valid_i) |=>
            state_time_o == (k ? 12'h00C : 12'h01C);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle entry");
endmodule : itd_asserts
bind instruction_timing_decode itd_asserts u_chk (.*);

// ### tb/seq_partner.sv
// Purpose: Sequencer model accepting offered times.
// Assumes: Waits delay_i cycles per offer.
// Notes: Delay 0 accepts at once.
`timescale 1ns/10ps
module seq_partner
(
    input logic clock_i,
    input logic rst_n_i,
    input logic time_valid_i,
    input logic [1:0] delay_i,
    output logic exec_start_o
);
    logic [1:0] wait_cnt;
    // Restarts per offer so every acceptance sees the same delay
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || !time_valid_i)
            wait_cnt <= 2'h0;
        else if (wait_cnt != 2'h3)
            wait_cnt <= wait_cnt + 2'h1;
    end
    assign exec_start_o = time_valid_i && (wait_cnt == delay_i);
endmodule : seq_partner

// ### tb/tb_top.sv
// Purpose: Bench for the decode block.
// Assumes: Partner accepts after dl cycles.
// Notes: Table, then hand cases.
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] sb;
        logic [4:0] fl;
        logic [1:0] pl;
        logic [7:0] n;
        logic [7:0] q;
        logic [11:0] t;
    } row_s;
    localparam int NR = 34;
    logic clock, rst_n, iv, tk, kv, m1, sm, om, st, tv, busy;
    logic [7:0] op, sb, sh, wc, ic;
    logic [1:0] pl, dl;
    logic [11:0] stime;
    logic [2:0] mode;
    logic [6:0] wreg;
    logic [10:0] disp;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    // Flags: {taken, key, 1M, stack mem, operand mem}
    row_s rows [NR] = '{
        '{8'hD7, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h004},
        '{8'hDB, 8'h00, 5'h10, 2'h0, 8'h00, 8'h00, 12'h008},
        '{8'hE0, 8'h00, 5'h10, 2'h0, 8'h00, 8'h00, 12'h009},
        '{8'h30, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h005},
        '{8'h3F, 8'h00, 5'h10, 2'h0, 8'h00, 8'h00, 12'h009},
        '{8'hE1, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h006},
        '{8'hE1, 8'h00, 5'h10, 2'h0, 8'h00, 8'h00, 12'h00A},
        '{8'h0F, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h009},
        '{8'h0F, 8'h00, 5'h00, 2'h0, 8'h03, 8'h00, 12'h00B},
        '{8'h09, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h007},
        '{8'h1A, 8'h00, 5'h00, 2'h0, 8'h0F, 8'h00, 12'h015},
        '{8'h0D, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h008},
        '{8'h0C, 8'h00, 5'h00, 2'h0, 8'h1F, 8'h00, 12'h026},
        '{8'hC1, 8'h00, 5'h00, 2'h0, 8'h02, 8'h00, 12'h016},
        '{8'hC1, 8'h00, 5'h00, 2'h1, 8'h03, 8'h00, 12'h027},
        '{8'hC1, 8'h00, 5'h00, 2'h2, 8'h01, 8'h00, 12'h014},
        '{8'hCD, 8'h00, 5'h00, 2'h1, 8'h02, 8'h01, 12'h02B},
        '{8'hF6, 8'h00, 5'h08, 2'h0, 8'h00, 8'h00, 12'h00C},
        '{8'hF6, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h01C},
        '{8'hE2, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h00F},
        '{8'hE2, 8'h00, 5'h00, 2'h1, 8'h00, 8'h00, 12'h012},
        '{8'hE2, 8'h00, 5'h00, 2'h2, 8'h00, 8'h00, 12'h015},
        '{8'hEF, 8'h00, 5'h04, 2'h0, 8'h00, 8'h00, 12'h00F},
        '{8'hEF, 8'h00, 5'h02, 2'h0, 8'h00, 8'h00, 12'h00D},
        '{8'h28, 8'h00, 5'h06, 2'h0, 8'h00, 8'h00, 12'h012},
        '{8'h2F, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h00B},
        '{8'hF0, 8'h00, 5'h04, 2'h0, 8'h00, 8'h00, 12'h010},
        '{8'hF0, 8'h00, 5'h02, 2'h0, 8'h00, 8'h00, 12'h00E},
        '{8'hF7, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h010},
        '{8'hF7, 8'h00, 5'h06, 2'h0, 8'h00, 8'h00, 12'h019},
        '{8'h8C, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h01A},
        '{8'h8D, 8'h00, 5'h00, 2'h0, 8'h00, 8'h00, 12'h01B},
        '{8'h66, 8'h34, 5'h00, 2'h0, 8'h00, 8'h00, 12'h006},
        '{8'h66, 8'h35, 5'h01, 2'h0, 8'h00, 8'h00, 12'h009}
    };
    instruction_timing_decode dut (
        .clock_i(clock), .rst_n_i(rst_n), .instr_valid_i(iv), .opcode_i(op),
        .second_byte_i(sb), .branch_taken_i(tk), .key_valid_i(kv), .mode_1mbyte_i(m1),
        .stack_in_memory_i(sm), .operand_in_memory_i(om), .move_place_i(pl),
        .shift_count_i(sh), .word_count_i(wc), .irq_count_i(ic), .exec_start_i(st),
        .time_valid_o(tv), .state_time_o(stime), .addr_mode_o(mode), .word_reg_o(wreg),
        .short_disp_o(disp), .busy_o(busy)
    );
    seq_partner u_seq (
        .clock_i(clock), .rst_n_i(rst_n), .time_valid_i(tv), .delay_i(dl),
        .exec_start_o(st)
    );
    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic launch(input row_s r);
        iv = 1'b1;
        op = r.op;
        sb = r.sb;
        {tk, kv, m1, sm, om} = r.fl;
        pl = r.pl;
        sh = r.n;
        wc = r.n;
        ic = r.q;
        @(posedge clock) #1;
        iv = 1'b0;
    endtask : launch
    task automatic settle;
        int w = 0;
        while (busy !== 1'b0 && w < 20)
        begin
            @(posedge clock) #1;
            w++;
        end
        check("idle", 12'(busy), 12'h000);
    endtask : settle
    task automatic issue(input row_s r);
        launch(r);
        check("offer", 12'(tv), 12'h001);
        settle();
    endtask : issue
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Run needs under two hundred cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    initial
    begin
        {rst_n, iv, tk, kv, m1, sm, om, dl} = '0;
        {op, sb, pl, sh, wc, ic} = '0;
        repeat (3) @(posedge clock);
        #1;
        rst_n = 1'b1;
        @(posedge clock) #1;
        check("reset offer", 12'(tv), 12'h000);
        check("reset time", stime, 12'h000);
        $display("reset test done");
        for (int i = 0; i < NR; i++)
        begin
            dl = 2'(i);
            issue(rows[i]);
            check("time", stime, rows[i].t);
        end
        $display("table test done");
        issue(row_s'{8'h67, 8'h35, 5'h00, 2'h0, 8'h00, 8'h00, 12'h000});
        check("mode", 12'(mode), 12'h005);
        check("reg", 12'(wreg), 12'h01A);
        issue(row_s'{8'h8E, 8'h34, 5'h00, 2'h0, 8'h00, 8'h00, 12'h000});
        check("mode", 12'(mode), 12'h002);
        check("divide", stime, 12'h01C);
        issue(row_s'{8'h2C, 8'hFF, 5'h04, 2'h0, 8'h00, 8'h00, 12'h000});
        check("disp", 12'(disp), 12'h4FF);
        issue(row_s'{8'h23, 8'h80, 5'h00, 2'h0, 8'h00, 8'h00, 12'h000});
        check("disp", 12'(disp), 12'h380);
        $display("mode test done");
        // Request while busy is ignored
        dl = 2'h3;
        launch(rows[19]);
        @(posedge clock) #1;
        launch(rows[17]);
        settle();
        check("refused", stime, 12'h00F);
        $display("refusal test done");
        launch(rows[20]);
        rst_n = 1'b0;
        @(posedge clock) #1;
        rst_n = 1'b1;
        check("mid reset busy", 12'(busy), 12'h000);
        check("mid reset offer", 12'(tv), 12'h000);
        @(posedge clock) #1;
        dl = 2'h0;
        issue(rows[21]);
        check("after reset", stime, 12'h015);
        $display("mid reset test done");
        report_and_stop();
    end
endmodule : tb_top
